/* File: hw/gauge_zero_pkg.sv */
// Purpose: shared constants and carriers for the gauge zero-return config and status block
// Assumes: 16-bit serial frames, address in the top 3 bits, data in the low 13 bits
// Notes: step times are held in units of 10 us, blanking in us
package gauge_zero_pkg;
  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_LSB = 13;
  localparam logic [2:0] ADDR_ZR_CMD = 3'h4;
  localparam logic [2:0] ADDR_ZR_CFG = 3'h5;
  // zero_return_command field positions
  localparam int CMD_RSVD_LSB = 5;
  localparam int CMD_UNCOND_BIT = 4;
  localparam int CMD_WIN_LSB = 2;
  localparam int CMD_EN_BIT = 1;
  localparam int CMD_SEL_BIT = 0;
  // zero_return_config reset values
  localparam logic [7:0] PRELOAD_RST = 8'h00;
  localparam logic BLANK_SEL_RST = 1'b0;
  localparam logic [3:0] STEP_CODE_RST = 4'h5;
  // accumulator
  localparam int ACC_W = 15;
  localparam logic [ACC_W-1:0] ACC_RST = 15'h7FFF;
  localparam logic [ACC_W-1:0] ACC_LAST_RST = 15'h0000;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int CNT_W = 24;
  localparam int BLANK_SHORT_US = 512;
  localparam int BLANK_LONG_US = 768;
  localparam int STEP_UNIT_US = 10;
  localparam int STEP_TIME_10US [16] = '{486, 486, 896, 1306, 1715, 2125, 2534, 2944,
                                         3354, 3763, 4173, 4582, 4992, 5402, 5811, 6221};

  typedef struct packed
  {
    logic [7:0] preload_value;
    logic blanking_select;
    logic [3:0] full_step_time_code;
  } zr_cfg_t;

  typedef struct packed
  {
    logic [7:0] accum_status_byte;
    logic clock_cal_fault;
    logic supply_fault;
    logic [1:0] moved;
    logic [1:0] zeroing_active;
    logic [1:0] overtemp;
  } status_t;

  typedef enum logic [2:0]
  {
    ZR_IDLE = 3'b001,
    ZR_BLANK = 3'b010,
    ZR_INTEG = 3'b100
  } zr_state_t;
endpackage

/* File: hw/gauge_zero_status.sv */
// Purpose: serial status word, frame length check, zero-return config and step timing
// Assumes: master drives sclk low while idle, samples so on sclk rising edge
// Notes: cs, sclk and si pins pass two flip-flops; so changes after each sampled sclk rise
`timescale 1ns/1ps

module gauge_zero_status
#(
  parameter int CYC_PER_US = gauge_zero_pkg::CLK_MHZ
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_n_o,
  // zero-return integrator
  input wire logic bemf_up_i,
  output logic full_step_o,
  output logic integrate_o,
  output logic [1:0] zeroing_o,
  output gauge_zero_pkg::zr_cfg_t zr_cfg_o,
  // fault and motion events
  input wire logic clk_cal_bad_i,
  input wire logic undervolt_i,
  input wire logic overvolt_i,
  input wire logic [1:0] pos_changed_i,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] gauge_enable_i,
  output logic [1:0] gauge_off_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // timing helpers

  localparam int CW = gauge_zero_pkg::CNT_W;
  localparam int AW = gauge_zero_pkg::ACC_W;
  localparam int ADDR_LSB_I = gauge_zero_pkg::ADDR_LSB;

  function automatic logic [CW-1:0] step_cycles(input logic [3:0] code);
    step_cycles = CW'(gauge_zero_pkg::STEP_TIME_10US[code] * gauge_zero_pkg::STEP_UNIT_US
                      * CYC_PER_US);
  endfunction

  function automatic logic [CW-1:0] blank_cycles(input logic sel);
    blank_cycles = sel ? CW'(gauge_zero_pkg::BLANK_LONG_US * CYC_PER_US)
                       : CW'(gauge_zero_pkg::BLANK_SHORT_US * CYC_PER_US);
  endfunction

  function automatic logic [7:0] acc_window(input logic [AW-1:0] acc, input logic [1:0] sel);
    case (sel)
      2'h0: acc_window = acc[7:0];
      2'h1: acc_window = acc[11:4];
      default: acc_window = {1'b0, acc[14:8]};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // state

  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic si_s1_reg, si_s2_reg;
  logic [15:0] shift_reg, shift_next;
  logic [15:0] bit_cnt_reg, bit_cnt_next;
  logic so_reg, so_next;
  logic so_oe_n_reg, so_oe_n_next;
  gauge_zero_pkg::zr_cfg_t cfg_reg, cfg_next;
  logic [1:0] win_sel_reg, win_sel_next;
  logic uncond_reg, uncond_next;
  logic supply_reg, supply_next;
  logic [1:0] moved_reg, moved_next;
  logic [1:0] zeroing_reg, zeroing_next;
  logic [1:0] zero_seen_reg, zero_seen_next;
  logic [1:0] overtemp_reg, overtemp_next;
  logic [1:0] gauge_off_reg, gauge_off_next;
  gauge_zero_pkg::zr_state_t state_reg, state_next;
  logic [CW-1:0] elapsed_reg, elapsed_next;
  logic [AW-1:0] acc_reg, acc_next;
  logic [AW-1:0] acc_last_reg, acc_last_next;
  logic full_step_reg, full_step_next;
  logic clk_cal_reg, clk_cal_next;

  gauge_zero_pkg::status_t status;
  logic cs_fall, cs_rise, sclk_rise, frame_ok, zr_run;
  logic [AW-1:0] preload;
  logic [AW-1:0] acc_step;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    cs_fall = cs_d_reg & ~cs_s2_reg;
    cs_rise = ~cs_d_reg & cs_s2_reg;
    sclk_rise = ~sclk_d_reg & sclk_s2_reg & ~cs_s2_reg;
    frame_ok = cs_rise && (bit_cnt_reg != 16'h0000) && (bit_cnt_reg[3:0] == 4'h0);
    // -(16*pv)-1 is the bitwise inverse of pv*16
    preload = ~{3'h0, cfg_reg.preload_value, 4'h0};

    status.accum_status_byte = acc_window(acc_last_reg, win_sel_reg);
    status.clock_cal_fault = clk_cal_reg;
    status.supply_fault = supply_reg;
    status.moved = moved_reg;
    status.zeroing_active = zeroing_reg;
    status.overtemp = overtemp_reg;

    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    so_oe_n_next = so_oe_n_reg;
    cfg_next = cfg_reg;
    win_sel_next = win_sel_reg;
    uncond_next = uncond_reg;
    supply_next = supply_reg;
    moved_next = moved_reg;
    zeroing_next = zeroing_reg;
    zero_seen_next = zero_seen_reg;
    overtemp_next = overtemp_reg;
    gauge_off_next = gauge_off_reg;
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    acc_next = acc_reg;
    acc_last_next = acc_last_reg;
    full_step_next = 1'b0;
    clk_cal_next = clk_cal_bad_i;

    // serial shifter; config is never loaded into it, only status
    if (cs_fall)
    begin
      shift_next = status;
      bit_cnt_next = 16'h0000;
      so_oe_n_next = 1'b0;
    end
    else if (sclk_rise)
    begin
      // input bits fall through behind the status word for chaining
      shift_next = {shift_reg[14:0], si_s2_reg};
      bit_cnt_next = bit_cnt_reg + 16'h0001;
    end
    if (cs_rise)
    begin
      so_oe_n_next = 1'b1;
    end

    // supply and motion clears happen only on a good frame, so a bad one resends them
    if (frame_ok)
    begin
      supply_next = 1'b0;
      moved_next = 2'b00;
      zeroing_next = zeroing_reg & ~zero_seen_reg;
      zero_seen_next = 2'b00;
      if (shift_reg[15:ADDR_LSB_I] == gauge_zero_pkg::ADDR_ZR_CFG)
      begin
        cfg_next = gauge_zero_pkg::zr_cfg_t'(shift_reg[12:0]);
      end
      if ((shift_reg[15:ADDR_LSB_I] == gauge_zero_pkg::ADDR_ZR_CMD)
          && (shift_reg[12:gauge_zero_pkg::CMD_RSVD_LSB] == 8'h00))
      begin
        win_sel_next = shift_reg[gauge_zero_pkg::CMD_WIN_LSB +: 2];
        uncond_next = shift_reg[gauge_zero_pkg::CMD_UNCOND_BIT];
        zeroing_next[shift_reg[gauge_zero_pkg::CMD_SEL_BIT]] =
          shift_reg[gauge_zero_pkg::CMD_EN_BIT];
      end
    end

    // events set after clears so a same-cycle event is kept
    supply_next = supply_next | undervolt_i | overvolt_i;
    moved_next = moved_next | pos_changed_i;
    overtemp_next = (overtemp_reg & ~gauge_enable_i) | overtemp_i;
    gauge_off_next = (gauge_off_reg & ~gauge_enable_i) | overtemp_i
                     | {2{overvolt_i}};

    // zero-return step timing and integration
    zr_run = |(zeroing_next & ~zero_seen_next);
    acc_step = bemf_up_i ? acc_reg + AW'(1) : acc_reg - AW'(1);
    case (state_reg)
      gauge_zero_pkg::ZR_IDLE:
      begin
        if (zr_run)
        begin
          state_next = gauge_zero_pkg::ZR_BLANK;
          elapsed_next = '0;
          acc_next = preload;
          full_step_next = 1'b1;
        end
      end
      gauge_zero_pkg::ZR_BLANK:
      begin
        elapsed_next = elapsed_reg + CW'(1);
        if (elapsed_reg == blank_cycles(cfg_reg.blanking_select) - CW'(1))
        begin
          state_next = gauge_zero_pkg::ZR_INTEG;
        end
      end
      gauge_zero_pkg::ZR_INTEG:
      begin
        elapsed_next = elapsed_reg + CW'(1);
        acc_next = acc_step;
        if (elapsed_reg == step_cycles(cfg_reg.full_step_time_code) - CW'(1))
        begin
          acc_last_next = acc_step;
          // negative result means stalled pointer unless forced mode
          if (acc_step[AW-1] && !uncond_reg)
          begin
            zero_seen_next = zero_seen_next | zeroing_next;
          end
          state_next = gauge_zero_pkg::ZR_IDLE;
          if (|(zeroing_next & ~zero_seen_next))
          begin
            state_next = gauge_zero_pkg::ZR_BLANK;
            elapsed_next = '0;
            acc_next = preload;
            full_step_next = 1'b1;
          end
        end
      end
      default:
      begin
        state_next = gauge_zero_pkg::ZR_IDLE;
      end
    endcase
    // master turning zero return off ends the step at once
    if (!zr_run && state_reg != gauge_zero_pkg::ZR_IDLE)
    begin
      state_next = gauge_zero_pkg::ZR_IDLE;
    end

    so_next = shift_next[15];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 16'h0000;
      so_reg <= 1'b0;
      so_oe_n_reg <= 1'b1;
      cfg_reg <= {gauge_zero_pkg::PRELOAD_RST, gauge_zero_pkg::BLANK_SEL_RST,
                  gauge_zero_pkg::STEP_CODE_RST};
      win_sel_reg <= 2'h0;
      uncond_reg <= 1'b0;
      supply_reg <= 1'b0;
      moved_reg <= 2'h0;
      zeroing_reg <= 2'h0;
      zero_seen_reg <= 2'h0;
      overtemp_reg <= 2'h0;
      gauge_off_reg <= 2'h0;
      state_reg <= gauge_zero_pkg::ZR_IDLE;
      elapsed_reg <= '0;
      acc_reg <= gauge_zero_pkg::ACC_RST;
      acc_last_reg <= gauge_zero_pkg::ACC_LAST_RST;
      full_step_reg <= 1'b0;
      clk_cal_reg <= 1'b0;
    end
    else
    begin
      cs_s1_reg <= cs_n_i;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg <= cs_s2_reg;
      sclk_s1_reg <= sclk_i;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      si_s1_reg <= si_i;
      si_s2_reg <= si_s1_reg;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      so_reg <= so_next;
      so_oe_n_reg <= so_oe_n_next;
      cfg_reg <= cfg_next;
      win_sel_reg <= win_sel_next;
      uncond_reg <= uncond_next;
      supply_reg <= supply_next;
      moved_reg <= moved_next;
      zeroing_reg <= zeroing_next;
      zero_seen_reg <= zero_seen_next;
      overtemp_reg <= overtemp_next;
      gauge_off_reg <= gauge_off_next;
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
      acc_reg <= acc_next;
      acc_last_reg <= acc_last_next;
      full_step_reg <= full_step_next;
      clk_cal_reg <= clk_cal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign so_o = so_reg;
  assign so_oe_n_o = so_oe_n_reg;
  assign full_step_o = full_step_reg;
  assign integrate_o = state_reg[2];
  assign zeroing_o = zeroing_reg;
  assign zr_cfg_o = cfg_reg;
  assign gauge_off_o = gauge_off_reg;

endmodule

/* File: sim/gauge_zero_status_sva.sv */
// Purpose: timing checks on the gauge zero-return config and status block
// Assumes: pins pass a two-flop sync and an edge detect inside the block
// Notes: step and blanking lengths allow two cycles of slack for the pipeline
`timescale 1ns/1ps
module gauge_zero_status_sva
#(
  parameter int CYC_PER_US = 200
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic cs_n_i,
  input wire logic so_oe_n_o,
  input wire logic full_step_o,
  input wire logic integrate_o,
  input wire logic [1:0] zeroing_o,
  input wire gauge_zero_pkg::zr_cfg_t zr_cfg_o,
  input wire logic overvolt_i,
  input wire logic [1:0] overtemp_i,
  input wire logic [1:0] gauge_enable_i,
  input wire logic [1:0] gauge_off_o
);
  int unsigned since_reg;
  int unsigned since_next;
  int unsigned blank_cyc;
  int unsigned step_cyc;

  always_comb
  begin
    since_next = full_step_o ? 1 : since_reg + 1;
    blank_cyc = (zr_cfg_o.blanking_select ? 768 : 512) * CYC_PER_US;
    step_cyc = gauge_zero_pkg::STEP_TIME_10US[zr_cfg_o.full_step_time_code] * 10 * CYC_PER_US;
  end

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      since_reg <= 0;
    else
      since_reg <= since_next;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  a_cfg_reset_value: assert property ($fell(rst_i) |-> zr_cfg_o == 13'h005)
    else $error("config not at reset value");
  a_so_drive_on: assert property ($fell(cs_n_i) |-> ##[3:5] !so_oe_n_o)
    else $error("so not driven after select fall");
  a_so_float_off: assert property ($rose(cs_n_i) |-> ##[3:5] so_oe_n_o)
    else $error("so not floated after select rise");
  a_cfg_frame_end: assert property ($changed(zr_cfg_o) |-> cs_n_i)
    else $error("config changed inside a frame");
  a_overtemp_off: assert property (overtemp_i != 2'h0 |->
    ##1 (gauge_off_o & $past(overtemp_i)) == $past(overtemp_i))
    else $error("overtemp did not disable gauge");
  a_overvolt_off: assert property (overvolt_i |-> ##[1:2] gauge_off_o == 2'h3)
    else $error("overvoltage did not disable drivers");
  a_off_until_enable: assert property ($fell(gauge_off_o[1]) |->
    $past(gauge_enable_i[1]))
    else $error("gauge re-enabled without enable");
  a_blank_length: assert property ($rose(integrate_o) |->
    since_reg + 2 >= blank_cyc && since_reg <= blank_cyc + 2)
    else $error("blanking length wrong");
  a_step_length: assert property (full_step_o && $past(|zeroing_o) |->
    since_reg + 2 >= step_cyc && since_reg <= step_cyc + 2)
    else $error("full step length wrong");
  a_step_on_start: assert property ($rose(|zeroing_o) |-> ##[0:1] full_step_o)
    else $error("no full step at zero-return start");
endmodule

bind gauge_zero_status gauge_zero_status_sva #(.CYC_PER_US(CYC_PER_US)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .so_oe_n_o(so_oe_n_o),
  .full_step_o(full_step_o), .integrate_o(integrate_o), .zeroing_o(zeroing_o),
  .zr_cfg_o(zr_cfg_o), .overvolt_i(overvolt_i), .overtemp_i(overtemp_i),
  .gauge_enable_i(gauge_enable_i), .gauge_off_o(gauge_off_o));

/* File: sim/spi_master_model.sv */
// Purpose: serial master driving the status block pins
// Assumes: sclk idles low; so is taken just before each sclk rise
// Notes: si shows the inverse of its last bit outside frames
`timescale 1ns/1ps
module spi_master_model
(
  // clock
  input wire logic clk_i,
  // serial pins
  input wire logic so_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o
);
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // 12 plus 13 cycles make the 125 ns serial period
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    cs_n_o = 1'b0;
    wait_clk(13);
    for (int i = n - 1; i >= 0; i--)
    begin
      si_o = tx[i];
      wait_clk(12);
      rx[i] = so_i;
      sclk_o = 1'b1;
      wait_clk(13);
      sclk_o = 1'b0;
    end
    wait_clk(12);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wait_clk(13);
  endtask
endmodule

/* File: sim/gauge_zero_status_bench.sv */
// Purpose: self-checking bench for the zero-return config and status block
// Assumes: CYC_PER_US of 1, so the shortest full step is 4860 cycles
// Notes: accumulator results follow the preload plus or minus one count per integrate cycle
`timescale 1ns/1ps
module gauge_zero_status_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n, sclk, si, so, so_oe_n, full_step, integrate;
  logic bemf_up = 1'b0;
  logic clk_cal_bad = 1'b0;
  logic undervolt = 1'b0;
  logic overvolt = 1'b0;
  logic [1:0] pos_changed = 2'h0;
  logic [1:0] overtemp = 2'h0;
  logic [1:0] gauge_enable = 2'h0;
  logic [1:0] zeroing, gauge_off;
  gauge_zero_pkg::zr_cfg_t zr_cfg;
  logic [31:0] rx;
  int n_errors = 0;
  int samples_checked = 0;

  always #2.5 clk_i = ~clk_i;

  gauge_zero_status #(.CYC_PER_US(1)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .so_o(so),
    .so_oe_n_o(so_oe_n), .bemf_up_i(bemf_up), .full_step_o(full_step),
    .integrate_o(integrate), .zeroing_o(zeroing), .zr_cfg_o(zr_cfg),
    .clk_cal_bad_i(clk_cal_bad), .undervolt_i(undervolt), .overvolt_i(overvolt),
    .pos_changed_i(pos_changed), .overtemp_i(overtemp), .gauge_enable_i(gauge_enable),
    .gauge_off_o(gauge_off));

  // a floated so shows the inverse, so early sampling cannot pass by luck
  spi_master_model master (.clk_i(clk_i), .so_i(so ^ so_oe_n), .cs_n_o(cs_n), .sclk_o(sclk),
    .si_o(si));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic read_status(input string what, input logic [15:0] exp);
    master.xfer(32'h0, 16, rx);
    check(what, {16'h0, exp}, rx);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("reset config", 32'h005, {19'h0, zr_cfg});
    check("reset flags", 32'h1, {27'h0, zeroing, gauge_off, so_oe_n});
  endtask

  // supply and motion flags latched until a valid frame, overtemp until enable; a bad length resends them
  task automatic t_faults();
    master.xfer(32'hA072, 16, rx);
    check("first status", 32'h0, rx);
    check("config write", 32'h072, {19'h0, zr_cfg});
    clk_cal_bad = 1'b1;
    undervolt = 1'b1;
    pos_changed = 2'h1;
    overtemp = 2'h2;
    @(negedge clk_i);
    {undervolt, pos_changed, overtemp} = 5'h0;
    master.xfer(32'hBFFF00, 24, rx);
    check("odd frame", 32'h00D2BF, rx);
    check("odd frame config", 32'h072, {19'h0, zr_cfg});
    read_status("resent status", 16'h00D2);
    clk_cal_bad = 1'b0;
    read_status("cleared status", 16'h0002);
    overvolt = 1'b1;
    @(negedge clk_i);
    overvolt = 1'b0;
    @(negedge clk_i);
    check("overvolt off", 32'h3, {30'h0, gauge_off});
    read_status("supply flag", 16'h0042);
    read_status("supply clear", 16'h0002);
    gauge_enable = 2'h3;
    @(negedge clk_i);
    gauge_enable = 2'h0;
    @(negedge clk_i);
    check("re-enabled", 32'h0, {30'h0, gauge_off});
    read_status("overtemp clear", 16'h0000);
  endtask

  task automatic t_echo();
    master.xfer(32'h1234BFF0, 32, rx);
    check("echo", 32'h00001234, rx);
    check("last word", 32'h1FF0, {19'h0, zr_cfg});
  endtask

  // preload 255 is -4081; 4092 integrate cycles give +11 rising, -8173 (15'h6013) falling
  task automatic t_zero();
    bemf_up = 1'b1;
    master.xfer(32'h8002, 16, rx);
    check("zeroing on", 32'h1, {30'h0, zeroing});
    master.wait_clk(4900);
    master.xfer(32'h0, 16, rx);
    check("step result", 32'h0B, {24'h0, rx[15:8]});
    check("zeroing bit", 32'h04, {24'h0, rx[7:0]});
    bemf_up = 1'b0;
    master.wait_clk(9300);
    read_status("stall seen", 16'h1304);
    check("zeroing off", 32'h0, {30'h0, zeroing});
    master.xfer(32'h8008, 16, rx);
    master.xfer(32'h0, 16, rx);
    check("sign window", 32'h6000, {16'h0, rx[15:0]});
    master.xfer(32'h8004, 16, rx);
    master.xfer(32'h0, 16, rx);
    check("mid window", 32'h01, {24'h0, rx[15:8]});
    // forced mode keeps stepping past a negative result until switched off
    master.xfer(32'h8013, 16, rx);
    master.wait_clk(4900);
    read_status("forced step", 16'h1308);
    master.xfer(32'h8001, 16, rx);
    check("forced off", 32'h0, {30'h0, zeroing});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_faults();
    t_echo();
    t_zero();
    results();
  end

  // whole run is near 28000 cycles
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule
